// [hdl/sfcs_pkg.sv]
// Constants, field layouts and carrier structs for the fieldbus register bank
// What this block does
// - Control bit 0 rising edge starts servo-on; held low in speed mode ramps down.
// - Control bit 1 low cancels pulses at once and inhibits power-on.
// - Control bit 2 low brakes fast, then cancels pulses, inhibits power-on.
// - Control bit 3 high allows operation; low inhibits it and cancels pulses.
// - Speed mode bit 4 runs ramp generator; low forces ramp output to zero.
// - Control bit 10 hands master control to the fieldbus master.
// - Speed mode bit 11 reverses rotation; reserved and ignored in torque mode.
// - With fieldbus source selected, servo-on and direction enables ignore terminals.
// - Relative positioning with immediate acceptance raises a positioning fault.
// - In torque mode a low ramp-stop bit does not stop the motor.
// - Status bits 0 to 9 report ready, fault, position, speed, limits, warning one.
// - Status bits 10 to 12 report warning two, referenced, second mode.
// - Simulation-select bits 0 to 9 put inputs 1 to 10 into simulation.
// - Simulation-value bits replace simulated terminal levels, edges included.
// - Speed mode input map fixes the role of each of the ten inputs.
package sfcs_pkg;
   localparam int unsigned DW = 16;
   localparam int unsigned AW = 16;
   localparam int unsigned NDI = 10;
   // Register addresses
   localparam logic [AW-1:0] ADDR_CTRL = 16'h9ca4;
   localparam logic [AW-1:0] ADDR_STAT = 16'h9cae;
   localparam logic [AW-1:0] ADDR_SIMSEL = 16'h9d59;
   localparam logic [AW-1:0] ADDR_SIMVAL = 16'h9d5b;
   // Reset values
   localparam logic [DW-1:0] CTRL_RST = 16'h0000;
   localparam logic [NDI-1:0] SIM_RST = 10'h000;
   // Control word fields
   localparam int unsigned CB_SON = 0;
   localparam int unsigned CB_COAST = 1;
   localparam int unsigned CB_QUICK = 2;
   localparam int unsigned CB_OPERATION_ENABLE = 3;
   localparam int unsigned CB_RAMP = 4;
   localparam int unsigned CB_IMMED = 5;
   localparam int unsigned CB_ABS = 6;
   localparam int unsigned CB_RESET = 7;
   localparam int unsigned CB_MASTER = 10;
   localparam int unsigned CB_REV = 11;
   localparam int unsigned CB_REF = 13;
   // Input terminal map in speed mode
   localparam int unsigned DI_SON = 0;
   localparam int unsigned DI_FAULT_RESET_INPUT = 1;
   localparam int unsigned DI_CWL = 2;
   localparam int unsigned DI_COUNTERCLOCKWISE_LIMIT = 3;
   localparam int unsigned DI_CWE = 4;
   localparam int unsigned DI_COUNTERCLOCKWISE_ENABLE = 5;
   localparam int unsigned DI_SPDA = 6;
   localparam int unsigned DI_SPDB = 7;
   localparam int unsigned DI_EMERGENCY_STOP = 8;
   localparam int unsigned DI_CMODE = 9;
   // Fast braking delay before pulse cancel, in ns
   localparam int unsigned CLK_NS = 4;
   localparam int unsigned QSTOP_NS = 1000;
   localparam int unsigned QSTOP_CYC = (QSTOP_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned CW = 12;

   typedef enum logic [1:0] {
      SFCS_POSITION,
      SFCS_INTPOS,
      SFCS_SPEED,
      SFCS_TORQUE
   } sfcs_mode_e;

   // Register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
   } sfcs_req_s;

   // Drive state reported into the status word
   typedef struct packed {
      logic in_position;
      logic zero_speed;
      logic speed_reached;
      logic torque_limit_reached;
      logic speed_limit_reached;
      logic holding_brake;
      logic overload_level_reached;
      logic warning_one;
      logic warning_two;
      logic referenced;
      logic second_mode;
   } sfcs_drv_s;

   // Decoded commands to the drive core
   typedef struct packed {
      logic servo_on;
      logic pulse_enable;
      logic ramp_stop;
      logic quick_stop;
      logic ramp_enable;
      logic reverse;
      logic fieldbus_master;
      logic fault_ack;
      logic clockwise_enable;
      logic counterclockwise_enable;
      logic clockwise_limit;
      logic counterclockwise_limit;
      logic speed_select_a;
      logic speed_select_b;
      logic emergency_stop;
      logic mode_change;
      logic referencing_start;
   } sfcs_cmd_s;
endpackage

// [hdl/sfcs_regs.sv]
// Fieldbus control and status register bank of the servo drive
`timescale 1ns/1ps
module sfcs_regs (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire sfcs_pkg::sfcs_req_s req,
   output logic [sfcs_pkg::DW-1:0] rdata,
   output logic rvalid,
   input wire sfcs_pkg::sfcs_mode_e mode,
   input wire logic control_source_select,
   input wire logic [sfcs_pkg::NDI-1:0] di_pins,
   input wire sfcs_pkg::sfcs_drv_s drv,
   input wire logic fault_in,
   output sfcs_pkg::sfcs_cmd_s cmd,
   output logic fault,
   output logic servo_ready
);
   import sfcs_pkg::*;

   // All checks below run on the core clock and sleep through reset
   default clocking cb_chk @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and pin synchronisers

   logic rst_a_r;
   logic rst_n;
   logic [NDI-1:0] di_m_r;
   logic [NDI-1:0] di_s_r;

   // Reset asserts at once but releases two edges late
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_a_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_a_r <= 1'b1;
         rst_n <= rst_a_r;
      end
   end

   // Terminals are asynchronous; second stage alone feeds logic
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         di_m_r <= SIM_RST;
         di_s_r <= SIM_RST;
      end else if (clk_en) begin
         di_m_r <= di_pins;
         di_s_r <= di_m_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes

   logic [DW-1:0] ctrl_r;
   logic [NDI-1:0] simsel_r;
   logic [NDI-1:0] simval_r;
   wire wr_ctrl = req.wr && (req.addr == ADDR_CTRL);
   wire wr_sel = req.wr && (req.addr == ADDR_SIMSEL);
   wire wr_val = req.wr && (req.addr == ADDR_SIMVAL);

   // Narrow registers keep only the ten input bits; upper bits read zero
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         simsel_r <= SIM_RST;
         simval_r <= SIM_RST;
      end else if (clk_en) begin
         if (wr_ctrl) ctrl_r <= req.wdata;
         if (wr_sel) simsel_r <= req.wdata[NDI-1:0];
         if (wr_val) simval_r <= req.wdata[NDI-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input simulation and source selection

   // Simulated inputs take the register bit, edges and all
   wire [NDI-1:0] di_eff = (simsel_r & simval_r) | (~simsel_r & di_s_r);
   wire is_speed = (mode == SFCS_SPEED);
   wire is_torque = (mode == SFCS_TORQUE);
   wire is_internal_positioning_mode = (mode == SFCS_INTPOS);
   wire bus_src = control_source_select;
   wire bus_master = ctrl_r[CB_MASTER];

   // Servo-on request: bus bit when the bus owns it, else terminal
   wire son_lvl = bus_src ? ctrl_r[CB_SON] : di_eff[DI_SON];

   ////////////////////////////////////////////////////////////////////////////
   // Drive sequence

   logic son_d_r;
   logic rst_d_r;
   logic fault_r;
   logic [CW-1:0] qcnt_r;
   logic [CW-1:0] qcnt_nxt;
   logic run_r;
   logic run_nxt;
   wire son_rise = son_lvl && !son_d_r;
   wire coast_n = ctrl_r[CB_COAST] && !(is_speed && di_eff[DI_EMERGENCY_STOP]);
   wire quick_n = ctrl_r[CB_QUICK];
   wire operation_enable = ctrl_r[CB_OPERATION_ENABLE];
   // Torque mode ignores a low ramp-stop level; only other stops act
   wire ramp_off = !son_lvl && !is_torque;
   wire ack = (bus_src && ctrl_r[CB_RESET]) ||
              (!bus_src && di_eff[DI_FAULT_RESET_INPUT]);
   // Relative positioning demands edge acceptance
   wire pos_err = is_internal_positioning_mode && ctrl_r[CB_IMMED] && !ctrl_r[CB_ABS];
   wire quick_done = (qcnt_r == CW'(QSTOP_CYC));

   // Run state: enable needs all stops clear; coast or inhibit drop at once
   always_comb begin
      run_nxt = run_r;
      qcnt_nxt = '0;
      if (!coast_n || !operation_enable || fault_r) begin
         run_nxt = 1'b0;
      end else if (!quick_n) begin
         qcnt_nxt = quick_done ? qcnt_r : qcnt_r + CW'(1);
         if (quick_done || !run_r) run_nxt = 1'b0;
      end else if (ramp_off && run_r) begin
         run_nxt = !drv.zero_speed;
      end else if (son_rise) begin
         run_nxt = 1'b1;
      end
   end

   // Fault set wins over the acknowledge in the same cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         son_d_r <= 1'b0;
         rst_d_r <= 1'b0;
         fault_r <= 1'b0;
         qcnt_r <= '0;
         run_r <= 1'b0;
      end else if (clk_en) begin
         son_d_r <= son_lvl;
         rst_d_r <= ack;
         qcnt_r <= qcnt_nxt;
         run_r <= run_nxt;
         if (fault_in || pos_err) fault_r <= 1'b1;
         else if (ack && !rst_d_r) fault_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command outputs

   wire [NDI-1:0] map = is_speed ? di_eff : SIM_RST;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd <= '0;
      end else if (clk_en) begin
         cmd.servo_on <= run_r;
         cmd.pulse_enable <= run_r && coast_n && operation_enable;
         cmd.ramp_stop <= ramp_off && run_r;
         cmd.quick_stop <= !quick_n && run_r;
         cmd.ramp_enable <= is_speed && ctrl_r[CB_RAMP] && run_r;
         cmd.reverse <= is_speed && ctrl_r[CB_REV];
         cmd.fieldbus_master <= bus_master;
         cmd.fault_ack <= ack && !rst_d_r;
         cmd.clockwise_enable <= bus_src ? (is_speed && !ctrl_r[CB_REV])
                                         : map[DI_CWE];
         cmd.counterclockwise_enable <= bus_src ? (is_speed && ctrl_r[CB_REV])
                                                : map[DI_COUNTERCLOCKWISE_ENABLE];
         cmd.clockwise_limit <= map[DI_CWL];
         cmd.counterclockwise_limit <= map[DI_COUNTERCLOCKWISE_LIMIT];
         cmd.speed_select_a <= map[DI_SPDA];
         cmd.speed_select_b <= map[DI_SPDB];
         cmd.emergency_stop <= map[DI_EMERGENCY_STOP];
         cmd.mode_change <= map[DI_CMODE];
         cmd.referencing_start <= is_internal_positioning_mode && bus_src && ctrl_r[CB_REF];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status word and read port

   wire [DW-1:0] stat = {3'h0, drv.second_mode, drv.referenced,
                         drv.warning_two, drv.warning_one,
                         drv.overload_level_reached, drv.holding_brake,
                         drv.speed_limit_reached, drv.torque_limit_reached,
                         drv.speed_reached, drv.zero_speed, drv.in_position,
                         fault_r, coast_n && quick_n && !fault_r};
   logic [DW-1:0] rmux;
   always_comb begin
      case (req.addr)
         ADDR_CTRL: rmux = ctrl_r;
         ADDR_STAT: rmux = stat;
         ADDR_SIMSEL: rmux = {6'h00, simsel_r};
         ADDR_SIMVAL: rmux = {6'h00, simval_r};
         default: rmux = 16'h0000;
      endcase
   end

   // Read data registered one cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
         rvalid <= 1'b0;
         fault <= 1'b0;
         servo_ready <= 1'b0;
      end else if (clk_en) begin
         rvalid <= req.rd;
         if (req.rd) rdata <= rmux;
         fault <= fault_r;
         servo_ready <= stat[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   // Edge seen while no stop holds the drive back
   sequence s_son_edge;
      (!son_lvl && clk_en) ##1
      (son_lvl && clk_en && coast_n && quick_n && operation_enable && !fault_r);
   endsequence

   // Ramp stop reaching standstill with no fast stop under way
   sequence s_ramp_down;
      clk_en && ramp_off && run_r && drv.zero_speed && quick_n;
   endsequence

   // Fast stop whose braking time has run out
   sequence s_quick_over;
      clk_en && !quick_n && quick_done;
   endsequence

   // Acknowledge edge with no new fault source in the same cycle
   sequence s_ack_clean;
      clk_en && fault_r && ack && !rst_d_r && !fault_in && !pos_err;
   endsequence

   chk_coast_kills_run: assert property (
      clk_en && !coast_n |=> !run_r)
      else $error("run survived coast stop");
   chk_coast_pulses: assert property (
      clk_en && !coast_n |=> !cmd.pulse_enable)
      else $error("pulses survived coast stop");
   chk_operation_enable_inhibit: assert property (
      clk_en && !operation_enable |=> !run_r)
      else $error("run survived operation inhibit");
   chk_operation_enable_pulses: assert property (
      clk_en && !operation_enable |=> !cmd.pulse_enable)
      else $error("pulses survived operation inhibit");
   chk_son_edge_run: assert property (
      s_son_edge |=> run_r)
      else $error("servo-on edge did not start run");
   chk_ramp_stop_end: assert property (
      s_ramp_down |=> !run_r)
      else $error("ramp stop did not end run");
   chk_quick_bound: assert property (
      qcnt_r <= CW'(QSTOP_CYC))
      else $error("quick stop counter overran");
   chk_quick_end: assert property (
      s_quick_over |=> !run_r)
      else $error("fast stop did not cancel pulses");
   chk_ramp_torque: assert property (
      clk_en && is_torque |=> !cmd.ramp_enable)
      else $error("ramp generator enabled in torque mode");
   chk_master_bit: assert property (
      clk_en |=> cmd.fieldbus_master == $past(ctrl_r[CB_MASTER]))
      else $error("master control bit not passed on");
   chk_reverse_speed: assert property (
      clk_en && !is_speed |=> !cmd.reverse)
      else $error("reversal acted outside speed mode");
   chk_bus_direction: assert property (
      clk_en && bus_src && !is_speed |=> !cmd.clockwise_enable)
      else $error("direction enable taken from terminals");
   chk_relpos_fault: assert property (
      clk_en && pos_err |=> fault_r)
      else $error("relative immediate setpoint not faulted");
   chk_torque_noramp: assert property (
      is_torque |-> !ramp_off)
      else $error("ramp stop acted in torque mode");
   chk_status_fault: assert property (
      clk_en && req.rd && req.addr == ADDR_STAT |=> rdata[1] == $past(fault_r))
      else $error("status fault bit wrong");
   chk_fault_set: assert property (
      clk_en && fault_in |=> fault_r)
      else $error("drive fault not latched");
   chk_status_top: assert property (
      clk_en && req.rd && req.addr == ADDR_STAT |=> rdata[15:13] == 3'h0)
      else $error("reserved status bits not zero");
   chk_sim_override: assert property (
      simsel_r[DI_SON] |-> di_eff[DI_SON] == simval_r[DI_SON])
      else $error("simulated input not overriding");
   chk_fault_ack: assert property (
      s_ack_clean |=> !fault_r)
      else $error("fault not cleared by acknowledge");
   chk_fault_sticky: assert property (
      clk_en && fault_r && !(ack && !rst_d_r) |=> fault_r)
      else $error("fault cleared without acknowledge");
   chk_read_answer: assert property (
      clk_en && req.rd |=> rvalid)
      else $error("read strobe not answered");
endmodule

// [bench/sfcs_plc_model.sv]
// Fieldbus master model issuing register requests to the bank
`timescale 1ns/1ps
module sfcs_plc_model (
   input wire logic core_clk,
   input wire logic [sfcs_pkg::DW-1:0] rdata,
   input wire logic rvalid,
   output sfcs_pkg::sfcs_req_s req
);
   import sfcs_pkg::*;
   initial req = '0;
   // Write: raised after a falling edge, taken at the next rising edge
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(negedge core_clk);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge core_clk);
      req.wr = 1'b0;
      // Released lines show the inverse so stale values never pass
      req.addr = ~a;
      req.wdata = ~d;
   endtask
   // Read: answer taken once the registered valid shows, x if none
   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
      int n;
      d = 'x;
      @(negedge core_clk);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge core_clk);
      req.rd = 1'b0;
      req.addr = ~a;
      for (n = 0; n < 3 && rvalid !== 1'b1; n++) begin
         @(negedge core_clk);
      end
      if (rvalid === 1'b1) begin
         d = rdata;
      end
   endtask
   // Servo-on needs a fresh edge on bit 0; all other bits of w pass unchanged
   task automatic servo_on_seq(input logic [DW-1:0] w);
      wr(ADDR_CTRL, w & 16'hfffe);
      wr(ADDR_CTRL, w | 16'h0001);
   endtask
endmodule

// [bench/servo_fieldbus_control_status_regs_test.sv]
// Self-checking bench for the fieldbus control and status register bank
`timescale 1ns/1ps
module servo_fieldbus_control_status_regs_test;
   import sfcs_pkg::*;
   logic core_clk = 1'b0;
   logic nrst;
   logic clk_en;
   sfcs_req_s req;
   logic [DW-1:0] rdata;
   logic rvalid;
   sfcs_mode_e mode;
   logic control_source_select;
   logic [NDI-1:0] di_pins;
   sfcs_drv_s drv;
   logic fault_in;
   sfcs_cmd_s cmd;
   logic fault;
   logic servo_ready;
   int bad_count = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [DW-1:0] rd_val;
   logic [NDI-1:0] sel;
   logic [NDI-1:0] val;
   logic [NDI-1:0] di_exp;

   sfcs_regs dut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .req(req), .rdata(rdata), .rvalid(rvalid), .mode(mode),
      .control_source_select(control_source_select), .di_pins(di_pins),
      .drv(drv), .fault_in(fault_in), .cmd(cmd), .fault(fault),
      .servo_ready(servo_ready));
   sfcs_plc_model plc (.core_clk(core_clk), .rdata(rdata),
      .rvalid(rvalid), .req(req));

   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard; the run needs well under 5000 cycles
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         final_report();
      end
   end

   // Comparison helpers and expectation functions
   task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp,
         input string what);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp, input string what);
      check({15'h0000, got}, {15'h0000, exp}, what);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp,
         input string what);
      plc.rd(a, rd_val);
      check(rd_val, exp, what);
   endtask
   function automatic logic [13:0] stat_hi(input sfcs_drv_s d);
      return {3'h0, d.second_mode, d.referenced, d.warning_two,
         d.warning_one, d.overload_level_reached, d.holding_brake,
         d.speed_limit_reached, d.torque_limit_reached, d.speed_reached,
         d.zero_speed, d.in_position};
   endfunction
   // Power up, apply one stop word, see whether pulses survive it
   task automatic stop_case(input sfcs_mode_e m, input logic [DW-1:0] w,
         input logic [DW-1:0] stop, input int n, input logic pulses);
      mode = m;
      plc.servo_on_seq(w);
      idle(4);
      chk1(cmd.pulse_enable, 1'b1, "pulses on");
      chk1(cmd.fieldbus_master, 1'b1, "bus master");
      plc.wr(ADDR_CTRL, stop);
      idle(n);
      chk1(cmd.pulse_enable, pulses, "after stop");
      $display("test stop %h done", stop);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      nrst = 1'b0;
      clk_en = 1'b1;
      mode = SFCS_SPEED;
      control_source_select = 1'b1;
      di_pins = '0;
      drv = '0;
      fault_in = 1'b0;
      void'($urandom(50));
      idle(16);
      nrst = 1'b1;
      idle(4);
      // Reset values, an unmapped place, narrow simulation registers
      rd_chk(ADDR_CTRL, CTRL_RST, "ctrl reset");
      rd_chk(ADDR_SIMVAL, 16'h0000, "simval reset");
      rd_chk(16'h9ca5, 16'h0000, "unmapped");
      plc.wr(ADDR_SIMSEL, 16'hffff);
      rd_chk(ADDR_SIMSEL, 16'h03ff, "simsel width");
      plc.wr(ADDR_SIMSEL, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         drv = sfcs_drv_s'($urandom);
         idle(2);
         plc.rd(ADDR_STAT, rd_val);
         check({2'h0, rd_val[15:2]}, {2'h0, stat_hi(drv)}, "status");
      end
      drv = '0;
      $display("test regs done");
      stop_case(SFCS_SPEED, 16'h041f, 16'h041d, 3, 1'b0);
      stop_case(SFCS_SPEED, 16'h041f, 16'h0417, 3, 1'b0);
      stop_case(SFCS_SPEED, 16'h041f, 16'h041b, 260, 1'b0);
      drv.zero_speed = 1'b1;
      stop_case(SFCS_SPEED, 16'h041f, 16'h041e, 6, 1'b0);
      drv.zero_speed = 1'b0;
      stop_case(SFCS_TORQUE, 16'h040f, 16'h040e, 20, 1'b1);
      stop_case(SFCS_TORQUE, 16'h040f, 16'h040d, 3, 1'b0);
      // Ramp, reversal and bus-owned direction enables in speed mode
      mode = SFCS_SPEED;
      di_pins = 10'h010;
      plc.servo_on_seq(16'h0c1f);
      idle(4);
      chk1(cmd.ramp_enable, 1'b1, "ramp on");
      chk1(cmd.reverse, 1'b1, "reverse");
      chk1(cmd.clockwise_enable, 1'b0, "cw bus");
      chk1(cmd.counterclockwise_enable, 1'b1, "ccw bus");
      di_pins = 10'h020;
      plc.wr(ADDR_CTRL, 16'h040f);
      idle(4);
      chk1(cmd.ramp_enable, 1'b0, "ramp off");
      chk1(cmd.reverse, 1'b0, "forward");
      chk1(cmd.clockwise_enable, 1'b1, "cw bus");
      $display("test direction done");
      // Fault is sticky until the acknowledge bit rises
      idle(1);
      fault_in = 1'b1;
      idle(1);
      fault_in = 1'b0;
      idle(2);
      chk1(fault, 1'b1, "fault set");
      chk1(servo_ready, 1'b0, "not ready");
      rd_chk(ADDR_STAT, 16'h0002, "fault stat");
      plc.wr(ADDR_CTRL, 16'h048f);
      idle(3);
      chk1(fault, 1'b0, "fault ack");
      chk1(servo_ready, 1'b1, "ready");
      rd_chk(ADDR_STAT, 16'h0001, "ready stat");
      plc.wr(ADDR_CTRL, 16'h040f);
      $display("test fault done");
      // Terminal levels merged with simulated ones
      control_source_select = 1'b0;
      for (int i = 0; i < 8; i++) begin
         sel = NDI'($urandom);
         val = NDI'($urandom);
         di_pins = NDI'($urandom);
         plc.wr(ADDR_SIMSEL, {6'h00, sel});
         plc.wr(ADDR_SIMVAL, {6'h00, val});
         idle(4);
         di_exp = (sel & val) | (~sel & di_pins);
         check({10'h000, cmd.clockwise_limit, cmd.counterclockwise_limit,
            cmd.speed_select_a, cmd.speed_select_b, cmd.emergency_stop,
            cmd.mode_change}, {10'h000, di_exp[DI_CWL], di_exp[DI_COUNTERCLOCKWISE_LIMIT],
            di_exp[DI_SPDA], di_exp[DI_SPDB], di_exp[DI_EMERGENCY_STOP],
            di_exp[DI_CMODE]}, "di map");
      end
      $display("test inputs done");
      // Relative positioning with immediate acceptance must fault
      control_source_select = 1'b1;
      di_pins = '0;
      plc.wr(ADDR_SIMSEL, 16'h0000);
      mode = SFCS_INTPOS;
      plc.wr(ADDR_CTRL, 16'h2420);
      idle(3);
      chk1(fault, 1'b1, "relpos fault");
      chk1(cmd.referencing_start, 1'b1, "ref start");
      plc.wr(ADDR_CTRL, 16'h2460);
      plc.wr(ADDR_CTRL, 16'h24e0);
      idle(3);
      chk1(fault, 1'b0, "abs fault ack");
      $display("test positioning done");
      final_report();
   end
endmodule
